// ==== design/rcdr_pkg.sv ====
/*
  Package for the reset cause recorder and debug forced reset block:
  register offsets, field layout, reset values and timing counts.
  Assumes a 16-bit CPU address bus with 8-bit data.
*/
package rcdr_pkg;

  // Register offsets on the CPU bus
  localparam logic [15:0] CAUSE_ADDR = 16'h1800;
  localparam logic [15:0] FORCE_ADDR = 16'h1801;

  // Illegal address windows
  localparam logic [15:0] GAP0_LO = 16'h0470;
  localparam logic [15:0] GAP0_HI = 16'h17FF;
  localparam logic [15:0] GAP1_LO = 16'h1860;
  localparam logic [15:0] GAP1_HI = 16'hBFFF;

  // Field positions
  localparam int POR_BIT    = 7;
  localparam int PIN_BIT    = 6;
  localparam int WDOG_BIT   = 5;
  localparam int ILLEGAL_OPCODE_FLAG_BIT   = 4;
  localparam int ILLEGAL_ADDRESS_FLAG_BIT   = 3;
  localparam int CLKGEN_BIT = 2;
  localparam int LOWV_BIT   = 1;
  localparam int DBGRST_BIT = 0;

  // Reset values
  localparam logic [7:0] CAUSE_POR_VAL = 8'h82;
  localparam logic [7:0] FORCE_RD_VAL  = 8'h00;

  // Timing: clock period and MCU reset hold time
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_HOLD_NS   = 640;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RST_HOLD_CNT = 8'(RST_HOLD_CYC);

  // Reset cause status layout
  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic illegal_opcode_flag;
    logic illegal_address_flag;
    logic clkgen;
    logic lowv;
    logic zero;
  } rcdr_cause_t;

  // Reset sources qualified this cycle
  typedef struct packed {
    logic lowv;
    logic pin;
    logic wdog;
    logic illegal_opcode_flag;
    logic illegal_address_flag;
    logic clkgen;
    logic dbg;
  } rcdr_src_t;

endpackage

// ==== design/rcdr_top.sv ====
/*
  Reset cause recorder with debug forced reset.
  Records which source produced the latest MCU reset, clears the
  watchdog on a write to the status address, and lets the background
  debug host force a reset. SYS_RST is the power-on reset; the block
  itself survives the MCU reset it drives out.
  Assumes bus strobes and source pulses come from REF_CLK logic; only
  the external reset pin is asynchronous.
*/
// Function
// - Seven read-only flags name last reset source
// - Debug forced reset leaves all flags cleared
// - Status write clears watchdog, keeps contents
// - Power-on sets power-on and low-voltage flags
// - Low-voltage reset keeps power-on flag, sets low-voltage
// - Other resets record active sources only
// - Bit 6 set by low reset pin
// - Bit 5 on watchdog timeout, gated by enable
// - Bit 4 on illegal opcode, or on stop or background opcode while its enable is low
// - Gap after RAM is illegal address
// - Gap before program memory is illegal address
// - Reserved register locations are never illegal
// - Bit 2 on clock generator reset request
// - Low-voltage trip resets when both enables set
// - Forced reset register ignores CPU writes
// - Forced reset register reads as zero
// - Debug write of bit 0 forces reset
`timescale 1ns/1ps
`default_nettype none
module rcdr_top (
  // Clock and power-on reset
  input  wire  logic        REF_CLK,
  input  wire  logic        SYS_RST,
  // CPU and debug bus
  input  wire  logic [15:0] BUS_ADDR,
  input  wire  logic        BUS_ACC,
  input  wire  logic        BUS_RD,
  input  wire  logic        BUS_WR,
  input  wire  logic        BUS_DBG,
  input  wire  logic [7:0]  BUS_WDATA,
  output var   logic [7:0]  BUS_RDATA,
  // External reset pin
  input  wire  logic        RESET_PIN_N,
  // Watchdog
  input  wire  logic        WDOG_TIMEOUT,
  input  wire  logic        WATCHDOG_ENABLE,
  output var   logic        WDOG_CLR,
  // Opcode decode
  input  wire  logic        OPC_UNIMPL,
  input  wire  logic        OPC_STOP,
  input  wire  logic        OPC_ENTER_BACKGROUND_INSTRUCTION,
  input  wire  logic        STOP_ENABLE,
  input  wire  logic        BACKGROUND_MODE_ENABLE,
  // Clock generator and low-voltage detector
  input  wire  logic        CLKGEN_RST_REQ,
  input  wire  logic        LVD_TRIP,
  input  wire  logic        LOW_VOLTAGE_RESET_ENABLE,
  input  wire  logic        LOW_VOLTAGE_STOP_ENABLE,
  // Reset to the rest of the MCU
  output var   logic        MCU_RST
);

  typedef enum logic [0:0] {ST_RUN, ST_HOLD} rcdr_state_t;

  rcdr_state_t          state_q;
  rcdr_state_t          state_d;
  rcdr_pkg::rcdr_cause_t cause_q;
  rcdr_pkg::rcdr_cause_t cause_d;
  logic [7:0]           hold_q;
  logic [7:0]           hold_d;
  logic                 pin_meta_q;
  logic                 pin_sync_q;
  logic [7:0]           rdata_q;
  logic                 wclr_q;

  // Pin is asynchronous, so two flops before any use
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= ~RESET_PIN_N;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Address decode
  wire hit_cause = (BUS_ADDR == rcdr_pkg::CAUSE_ADDR);
  wire hit_force = (BUS_ADDR == rcdr_pkg::FORCE_ADDR);
  wire in_gap0   = (BUS_ADDR >= rcdr_pkg::GAP0_LO) && (BUS_ADDR <= rcdr_pkg::GAP0_HI);
  wire in_gap1   = (BUS_ADDR >= rcdr_pkg::GAP1_LO) && (BUS_ADDR <= rcdr_pkg::GAP1_HI);
  // Only the two gaps count; register pages sit outside them
  wire illegal_address_flag_hit  = BUS_ACC && !BUS_DBG && (in_gap0 || in_gap1);

  // Qualified reset sources
  rcdr_pkg::rcdr_src_t src;
  assign src.lowv   = LVD_TRIP && LOW_VOLTAGE_RESET_ENABLE && LOW_VOLTAGE_STOP_ENABLE;
  assign src.pin    = pin_sync_q;
  assign src.wdog   = WDOG_TIMEOUT && WATCHDOG_ENABLE;
  assign src.illegal_opcode_flag   = OPC_UNIMPL || (OPC_STOP && !STOP_ENABLE)
                      || (OPC_ENTER_BACKGROUND_INSTRUCTION && !BACKGROUND_MODE_ENABLE);
  assign src.illegal_address_flag   = illegal_address_flag_hit;
  assign src.clkgen = CLKGEN_RST_REQ;
  // CPU writes never reach the force bit; only debug writes do
  assign src.dbg    = BUS_WR && BUS_DBG && hit_force
                      && BUS_WDATA[rcdr_pkg::DBGRST_BIT];

  wire any_src = |src;

  // Flag image for a non low-voltage reset; debug contributes nothing
  rcdr_pkg::rcdr_cause_t other_img;
  assign other_img.por    = 1'b0;
  assign other_img.pin    = src.pin;
  assign other_img.wdog   = src.wdog;
  assign other_img.illegal_opcode_flag   = src.illegal_opcode_flag;
  assign other_img.illegal_address_flag   = src.illegal_address_flag;
  assign other_img.clkgen = src.clkgen;
  assign other_img.lowv   = 1'b0;
  assign other_img.zero   = 1'b0;

  // Flag image for a low-voltage reset
  rcdr_pkg::rcdr_cause_t lowv_img;
  assign lowv_img = '{por: cause_q.por, lowv: 1'b1, default: 1'b0};

  // Sources still active during the hold are added, but a
  // low-voltage hold keeps its own image
  rcdr_pkg::rcdr_cause_t hold_img;
  assign hold_img = src.lowv ? lowv_img : (cause_q.lowv ? cause_q : (cause_q | other_img));

  wire hold_done = (hold_q == 8'h00) && !pin_sync_q;

  // Reset sequencer and cause capture
  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    hold_d  = hold_q;
    case (state_q)
      ST_RUN: begin
        if (any_src) begin
          state_d = ST_HOLD;
          hold_d  = rcdr_pkg::RST_HOLD_CNT;
          // A pure debug reset yields an all-zero image
          cause_d = src.lowv ? lowv_img : other_img;
        end
      end
      ST_HOLD: begin
        cause_d = hold_img;
        if (hold_q != 8'h00) begin
          hold_d = hold_q - 8'h01;
        end
        if (hold_done) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Power-on leaves power-on and low-voltage flags set
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_RUN;
      cause_q <= rcdr_pkg::CAUSE_POR_VAL;
      hold_q  <= 8'h00;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      hold_q  <= hold_d;
    end
  end

  // Read mux: status is read-only, forced reset reads zero
  wire [7:0] rd_mux = hit_cause ? cause_q : rcdr_pkg::FORCE_RD_VAL;

  // Registered read data; a status write only kicks the watchdog
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_q <= 8'h00;
      wclr_q  <= 1'b0;
    end else begin
      rdata_q <= (BUS_RD && (hit_cause || hit_force)) ? rd_mux : 8'h00;
      wclr_q  <= BUS_WR && hit_cause;
    end
  end

  // Outputs
  assign BUS_RDATA = rdata_q;
  assign WDOG_CLR  = wclr_q;
  assign MCU_RST   = (state_q == ST_HOLD);

endmodule
`default_nettype wire

// ==== bench/rcdr_checker.sv ====
/*
  Port assertions for the reset cause recorder.
  Assumes a bind to rcdr_top and one REF_CLK domain.
*/
`timescale 1ns/1ps
`default_nettype none
module rcdr_checker (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // Bus
  input wire logic        BUS_ACC,
  input wire logic        BUS_RD,
  input wire logic        BUS_WR,
  input wire logic        BUS_DBG,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [7:0]  BUS_WDATA,
  input wire logic [7:0]  BUS_RDATA,
  // Sources
  input wire logic        WDOG_TIMEOUT,
  input wire logic        WATCHDOG_ENABLE,
  input wire logic        OPC_UNIMPL,
  input wire logic        LVD_TRIP,
  input wire logic        LOW_VOLTAGE_RESET_ENABLE,
  input wire logic        LOW_VOLTAGE_STOP_ENABLE,
  // Outputs
  input wire logic        WDOG_CLR,
  input wire logic        MCU_RST
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // Decoded bus events; debug accesses never count as gaps
  wire logic st_wr = BUS_WR && BUS_ADDR == rcdr_pkg::CAUSE_ADDR;
  wire logic fr_hit = BUS_ADDR == rcdr_pkg::FORCE_ADDR;
  wire logic gap = BUS_ACC && !BUS_DBG && BUS_ADDR inside {[rcdr_pkg::GAP0_LO:rcdr_pkg::GAP0_HI]};
  wire logic gap_hi = BUS_ACC && !BUS_DBG && BUS_ADDR inside {[rcdr_pkg::GAP1_LO:rcdr_pkg::GAP1_HI]};
  wire logic lv = LVD_TRIP && LOW_VOLTAGE_RESET_ENABLE && LOW_VOLTAGE_STOP_ENABLE;

  clr_pulse_a: assert property (st_wr |=> WDOG_CLR) else $error("no wdog clear");
  clr_cause_a: assert property (WDOG_CLR |-> $past(st_wr)) else $error("stray wdog clear");
  force_rd_a: assert property (BUS_RD && fr_hit |=> BUS_RDATA == 8'h00) else $error("force read");
  bit_zero_a: assert property (BUS_RDATA[0] == 1'b0) else $error("bit 0 set");
  dbg_rst_a: assert property (BUS_WR && BUS_DBG && fr_hit && BUS_WDATA[0] |=> MCU_RST) else $error("dbg rst");
  wdog_rst_a: assert property (WDOG_TIMEOUT && WATCHDOG_ENABLE |=> MCU_RST) else $error("wdog rst");
  illegal_opcode_flag_rst_a: assert property (OPC_UNIMPL |=> MCU_RST) else $error("opcode rst");
  lowv_rst_a: assert property (lv |=> MCU_RST) else $error("low voltage rst");
  gap_rst_a: assert property (gap |=> MCU_RST) else $error("gap rst");
  gap_hi_rst_a: assert property (gap_hi |=> MCU_RST) else $error("upper gap rst");
  hold_len_a: assert property ($rose(MCU_RST) |-> ##32 MCU_RST) else $error("short reset");
endmodule
bind rcdr_top rcdr_checker u_chk (.REF_CLK, .SYS_RST, .BUS_ACC, .BUS_RD, .BUS_WR, .BUS_DBG, .BUS_ADDR,
  .BUS_WDATA, .BUS_RDATA, .WDOG_TIMEOUT, .WATCHDOG_ENABLE, .OPC_UNIMPL, .LVD_TRIP, .WDOG_CLR, .MCU_RST,
  .LOW_VOLTAGE_RESET_ENABLE, .LOW_VOLTAGE_STOP_ENABLE);
`default_nettype wire

// ==== bench/rcdr_host.sv ====
/*
  Bus master model for CPU software and the serial debug host.
  Assumes strobes are sampled on rising clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module rcdr_host (
  // Clock
  input  wire logic        clk,
  // Bus towards the block
  output var  logic [15:0] addr,
  output var  logic        acc,
  output var  logic        rd,
  output var  logic        wr,
  output var  logic        dbg,
  output var  logic [7:0]  wdata,
  input  wire logic [7:0]  rdata
);
  initial {addr, acc, rd, wr, dbg, wdata} = '0;
  // One access held to the next edge; debug accesses leave acc low, so they are not memory accesses
  task automatic xfer(input logic [15:0] a, input logic r, w, d, input logic [7:0] wd, output logic [7:0] q);
    addr <= a;
    acc <= ~d;
    rd <= r;
    wr <= w;
    dbg <= d;
    wdata <= wd;
    @(posedge clk);
    {acc, rd, wr, dbg} <= 4'h0;
    addr <= ~a; // Released bus shows no stale value
    wdata <= ~wd;
    #1 q = rdata;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
/*
  Testbench for the reset cause recorder.
  Assumes the checker is bound; rcdr_host drives the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rst, acc, rd, wr, dbg, wdclr, mrst;
  logic [6:0]  s;
  logic [4:0]  en;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, q;
  int          fails, samples_checked;
  wire logic   pin_n = ~s[6];
  // Entries: reset expected, sources, enables, status
  logic [27:0] tt [11] = '{28'h1_20_1F_82, 28'h0_20_0F_82, 28'h0_01_1E_82, 28'h0_04_1F_82,
    28'h1_01_1F_20, 28'h1_02_1F_10, 28'h1_04_1D_10, 28'h1_08_1B_10, 28'h1_10_1F_04,
    28'h1_40_1F_40, 28'h1_20_1F_02};

  rcdr_top u_dut (.REF_CLK(clk), .SYS_RST(rst), .BUS_ADDR(addr), .BUS_ACC(acc), .BUS_RD(rd),
    .BUS_WR(wr), .BUS_DBG(dbg), .BUS_WDATA(wdata), .BUS_RDATA(rdata), .RESET_PIN_N(pin_n),
    .WDOG_TIMEOUT(s[0]), .WATCHDOG_ENABLE(en[0]), .WDOG_CLR(wdclr), .OPC_UNIMPL(s[1]),
    .OPC_STOP(s[2]), .OPC_ENTER_BACKGROUND_INSTRUCTION(s[3]), .STOP_ENABLE(en[1]), .BACKGROUND_MODE_ENABLE(en[2]),
    .CLKGEN_RST_REQ(s[4]), .LVD_TRIP(s[5]), .LOW_VOLTAGE_RESET_ENABLE(en[3]),
    .LOW_VOLTAGE_STOP_ENABLE(en[4]), .MCU_RST(mrst));
  rcdr_host h (.clk, .addr, .acc, .rd, .wr, .dbg, .wdata, .rdata);

  task automatic chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Count reset cycles, then read status back
  task automatic settle(input logic [7:0] n, x);
    logic [7:0] hi;
    hi = {7'h00, mrst}; // Callers enter just past the edge that starts the hold
    repeat (50) begin
      @(posedge clk);
      #1 hi += {7'h00, mrst};
    end
    chk(hi, n);
    h.xfer(rcdr_pkg::CAUSE_ADDR, 1, 0, 0, 8'h00, q);
    chk(q, x);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is about 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    {rst, s, en, fails, samples_checked} = {1'b1, 7'h00, 5'h1F, 64'h0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    settle(8'h00, 8'h82);
    h.xfer(16'h1801, 1, 0, 0, 8'h00, q);
    chk(q, 8'h00);
    h.xfer(16'h1800, 0, 1, 0, 8'hFF, q);
    chk({7'h00, wdclr}, 8'h01);
    settle(8'h00, 8'h82);
    for (int i = 0; i < 11; i++) begin
      en <= tt[i][12:8];
      @(posedge clk);
      s <= tt[i][22:16];
      @(posedge clk);
      s <= 7'h00;
      #1; // Same phase as the bus task, so the first held cycle is counted
      settle(tt[i][24] ? 8'h21 : 8'h00, tt[i][7:0]);
    end
    h.xfer(16'h0470, 0, 0, 0, 8'h00, q);
    settle(8'h21, 8'h08);
    h.xfer(16'h1802, 1, 0, 0, 8'h00, q);
    settle(8'h00, 8'h08);
    h.xfer(16'hBFFF, 0, 0, 0, 8'h00, q);
    settle(8'h21, 8'h08);
    h.xfer(16'h1801, 0, 1, 0, 8'h01, q);
    settle(8'h00, 8'h08);
    h.xfer(16'h1801, 0, 1, 1, 8'h01, q);
    settle(8'h21, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
